// ===== rtl/blt_pkg.sv
// Package for the window lookup-table translation block.
// Assumes a single core clock and a plain register port.
package blt_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_LUT_ENTRY_POINTER = 8'h00;
  localparam logic [7:0] ADDR_LUT_LOW_WORD      = 8'h04;
  localparam logic [7:0] ADDR_LUT_MID_WORD      = 8'h08;
  localparam logic [7:0] ADDR_LUT_HIGH_WORD     = 8'h0c;
  localparam logic [7:0] ADDR_WINDOW_SETUP_REG  = 8'h10;
  localparam logic [7:0] ADDR_PART_CTRL         = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS        = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE        = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_CLEAR         = 8'h20;
  localparam logic [7:0] ADDR_XLAT_LOW          = 8'h24;
  localparam logic [7:0] ADDR_XLAT_HIGH         = 8'h28;

  // ****************************************
  // Field layout and limits
  // ****************************************
  localparam int          LUT_ENTRIES    = 24;
  localparam int          LUT_IDX_W      = 5;
  localparam int          WIN_NUM        = 2;
  localparam logic [5:0]  SIZE_MIN       = 6'h0e;
  localparam logic [5:0]  SIZE_MAX       = 6'h25;
  localparam logic [5:0]  SIZE_RST       = 6'h0e;
  localparam int          PTR_WIN_BIT    = 8;
  localparam int          PART_W         = 3;
  localparam int          VALID_BIT      = 0;
  localparam int          PART_LSB       = 1;
  localparam logic [31:0] LOW_ADDR_MASK  = 32'hffff_f000;
  localparam logic [7:0]  ACTIVE_RST     = 8'hff;
  localparam logic [2:0]  SRC_PART_RST   = 3'h0;
  localparam int          IRQ_W          = 4;
  localparam int          IRQ_UR_OOB     = 0;
  localparam int          IRQ_UR_INV     = 1;
  localparam int          IRQ_UR_PART    = 2;
  localparam int          IRQ_XLAT_OK    = 3;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] func;
  } blt_id_t;

  typedef struct packed {
    logic        valid;
    logic        win;
    logic        is_cpl;
    logic        addr64;
    logic [63:0] addr;
    blt_id_t     req_id;
    blt_id_t     cpl_id;
  } blt_req_t;

  typedef struct packed {
    logic        valid;
    logic        ur;
    logic [63:0] addr;
    logic [2:0]  part;
    blt_id_t     req_id;
    blt_id_t     cpl_id;
  } blt_rsp_t;

endpackage : blt_pkg

// ===== rtl/blt_lut_xlat.sv
// Lookup-table address translation for two memory windows of an NT endpoint.
// Assumes requests arrive from logic on i_clk; registers on a plain port.
//
// Behaviour
// - Size 14..37 selects five index bits
// - Size 37 uses index [36:32], offset [31:0]
// - 32-bit requests use address bits 31 down
// - Both windows share pointer and three data words
// - Data-word reads return selected entry fields
// - Data-word writes update selected entry fields
// - Pointer holds window-select and index fields
// - Table contents survive non-fundamental resets
// - Fundamental reset clears every valid flag
// - ID splits into bus, device, function
// - Requests give requester ID; completions both
// - Index 24..31 is unsupported request
// - Invalid entry gives unsupported request
// - Output address is base plus offset
// - Bad or same destination partition unsupported
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module blt_lut_xlat
  import blt_pkg::*;
#(
  parameter int N_ENTRIES = LUT_ENTRIES
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_fund_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire blt_req_t    i_req,
  output blt_rsp_t         o_rsp,
  output logic             o_irq
);

  // ****************************************
  // Table storage
  // ****************************************
  // Valid flags are the only state cleared; data arrays never reset.
  logic [63:0]       base_mem  [WIN_NUM][N_ENTRIES];
  logic [PART_W-1:0] part_mem  [WIN_NUM][N_ENTRIES];
  logic [N_ENTRIES-1:0] valid_ff [WIN_NUM];

  // ****************************************
  // Registers
  // ****************************************
  logic                 ptr_win_ff;
  logic [LUT_IDX_W-1:0] ptr_idx_ff;
  logic [5:0]           size_ff [WIN_NUM];
  logic [7:0]           active_ff;
  logic [PART_W-1:0]    src_part_ff;
  logic [IRQ_W-1:0]     irq_sts_ff;
  logic [IRQ_W-1:0]     irq_en_ff;
  logic [63:0]          xlat_last_ff;
  logic [31:0]          rdata_ff;
  blt_rsp_t             rsp_ff;

  function automatic logic [5:0] clamp_size(input logic [5:0] s);
    if (s < SIZE_MIN) begin
      return SIZE_MIN;
    end else if (s > SIZE_MAX) begin
      return SIZE_MAX;
    end
    return s;
  endfunction

  // ****************************************
  // Register decode
  // ****************************************
  wire sel_ptr   = (i_addr == ADDR_LUT_ENTRY_POINTER);
  wire sel_low   = (i_addr == ADDR_LUT_LOW_WORD);
  wire sel_mid   = (i_addr == ADDR_LUT_MID_WORD);
  wire sel_high  = (i_addr == ADDR_LUT_HIGH_WORD);
  wire sel_setup = (i_addr == ADDR_WINDOW_SETUP_REG);
  wire sel_part  = (i_addr == ADDR_PART_CTRL);
  wire sel_sts   = (i_addr == ADDR_IRQ_STATUS);
  wire sel_en    = (i_addr == ADDR_IRQ_ENABLE);
  wire sel_clr   = (i_addr == ADDR_IRQ_CLEAR);
  wire sel_xl    = (i_addr == ADDR_XLAT_LOW);
  wire sel_xh    = (i_addr == ADDR_XLAT_HIGH);

  // Pointer entries 24..31 have no storage; accesses there are dropped
  wire ptr_ok = (ptr_idx_ff < LUT_IDX_W'(N_ENTRIES));
  wire [LUT_IDX_W-1:0] pidx = ptr_ok ? ptr_idx_ff : '0;

  wire [63:0]       cur_base  = base_mem[ptr_win_ff][pidx];
  wire [PART_W-1:0] cur_part  = part_mem[ptr_win_ff][pidx];
  wire              cur_valid = ptr_ok & valid_ff[ptr_win_ff][pidx];

  // Low word: base[31:12], partition, valid
  wire [31:0] low_word = {cur_base[31:12], 8'h00, cur_part, cur_valid};
  wire [31:0] rd_mux =
      sel_ptr   ? {23'h0, ptr_win_ff, 3'h0, ptr_idx_ff} :
      sel_low   ? (ptr_ok ? low_word : 32'h0) :
      sel_mid   ? (ptr_ok ? {cur_base[31:12], 12'h000} : 32'h0) :
      32'h0;

  // ****************************************
  // Request translation
  // ****************************************
  wire [5:0]  req_size = clamp_size(size_ff[i_req.win]);
  // 32-bit addresses only look at bits 31 down
  wire [63:0] req_addr = i_req.addr64 ? i_req.addr : {32'h0, i_req.addr[31:0]};
  wire [5:0]  off_w    = req_size - 6'(LUT_IDX_W);
  wire [63:0] off_mask = (64'h1 << off_w) - 64'h1;
  wire [LUT_IDX_W-1:0] req_idx = LUT_IDX_W'(req_addr >> off_w);
  wire        idx_oob  = (req_idx >= LUT_IDX_W'(N_ENTRIES));
  wire [LUT_IDX_W-1:0] ridx = idx_oob ? '0 : req_idx;
  wire        ent_ok   = !idx_oob && valid_ff[i_req.win][ridx];
  wire [PART_W-1:0] dst = part_mem[i_req.win][ridx];
  wire        part_bad = !active_ff[dst] || (dst == src_part_ff);
  wire [63:0] xl_addr  = base_mem[i_req.win][ridx] + (req_addr & off_mask);
  wire        ur       = idx_oob || !ent_ok || part_bad;

  wire [IRQ_W-1:0] ev = {IRQ_W{i_req.valid}} &
      {!ur, ent_ok & part_bad, !idx_oob & !ent_ok, idx_oob};

  // ****************************************
  // Sequential logic
  // ****************************************
  // Table writes; not reset so contents ride through ordinary resets
  always_ff @(posedge i_clk) begin
    if (i_wr && ptr_ok && sel_low) begin
      // Base is page aligned; low bits held at zero so base plus offset is defined
      base_mem[ptr_win_ff][pidx][31:12] <= i_wdata[31:12];
      base_mem[ptr_win_ff][pidx][11:0]  <= 12'h000;
      part_mem[ptr_win_ff][pidx]        <= i_wdata[PART_LSB +: PART_W];
    end
    if (i_wr && ptr_ok && sel_mid) begin
      base_mem[ptr_win_ff][pidx][31:0]  <= {i_wdata[31:12], base_mem[ptr_win_ff][pidx][11:0]};
    end
    if (i_wr && ptr_ok && sel_high) begin
      base_mem[ptr_win_ff][pidx][63:32] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    for (int w = 0; w < WIN_NUM; w++) begin
      if (i_fund_rst) begin
        valid_ff[w] <= '0;
      end else if (i_wr && ptr_ok && sel_low && ptr_win_ff == w[0]) begin
        valid_ff[w][pidx] <= i_wdata[VALID_BIT];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || i_fund_rst) begin
      ptr_win_ff   <= 1'b0;
      ptr_idx_ff   <= '0;
      size_ff[0]   <= SIZE_RST;
      size_ff[1]   <= SIZE_RST;
      active_ff    <= ACTIVE_RST;
      src_part_ff  <= SRC_PART_RST;
      irq_sts_ff   <= '0;
      irq_en_ff    <= '0;
      xlat_last_ff <= '0;
      rdata_ff     <= '0;
      rsp_ff       <= '0;
    end else begin
      if (i_wr && sel_ptr) begin
        ptr_win_ff <= i_wdata[PTR_WIN_BIT];
        ptr_idx_ff <= i_wdata[LUT_IDX_W-1:0];
      end
      if (i_wr && sel_setup) begin
        size_ff[0] <= clamp_size(i_wdata[5:0]);
        size_ff[1] <= clamp_size(i_wdata[13:8]);
      end
      if (i_wr && sel_part) begin
        active_ff   <= i_wdata[7:0];
        src_part_ff <= i_wdata[8 +: PART_W];
      end
      if (i_wr && sel_en) begin
        irq_en_ff <= i_wdata[IRQ_W-1:0];
      end
      // Set wins over a clear in the same cycle
      irq_sts_ff <= (irq_sts_ff & ~((i_wr && sel_clr) ? i_wdata[IRQ_W-1:0] : '0)) | ev;
      if (i_req.valid && !ur) begin
        xlat_last_ff <= xl_addr;
      end
      rdata_ff <= !i_rd ? 32'h0 :
                  sel_high ? (ptr_ok ? cur_base[63:32] : 32'h0) :
                  sel_mid  ? (ptr_ok ? {cur_base[31:12], 12'h0} : 32'h0) :
                  sel_setup ? {18'h0, size_ff[1], 2'h0, size_ff[0]} :
                  sel_part ? {21'h0, src_part_ff, active_ff} :
                  sel_sts  ? {28'h0, irq_sts_ff} :
                  sel_en   ? {28'h0, irq_en_ff} :
                  sel_xl   ? xlat_last_ff[31:0] :
                  sel_xh   ? xlat_last_ff[63:32] :
                  rd_mux;
      rsp_ff.valid  <= i_req.valid;
      rsp_ff.ur     <= ur;
      rsp_ff.addr   <= ur ? 64'h0 : xl_addr;
      rsp_ff.part   <= dst;
      rsp_ff.req_id <= i_req.req_id;
      rsp_ff.cpl_id <= i_req.is_cpl ? i_req.cpl_id : '0;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_rsp   = rsp_ff;
  assign o_irq   = |(irq_sts_ff & irq_en_ff);

endmodule // blt_lut_xlat

// ===== verif/blt_requester.sv
// Requester model that feeds translation requests to the block.
// Assumes the bench sets i_cmd beside a one-cycle i_go strobe.
`timescale 1ns/1ns
module blt_requester
  import blt_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_go,
  input  wire blt_req_t i_cmd,
  output blt_req_t      o_req
);
  initial o_req = '0;
  // Idle cycles flip the address so a stale value never passes for a request
  always @(posedge i_clk) begin
    if (i_go) begin
      o_req <= i_cmd;
    end else begin
      o_req.valid <= 1'b0;
      o_req.addr  <= ~o_req.addr;
    end
  end
endmodule // blt_requester

// ===== verif/blt_lut_xlat_properties.sv
// Port checker for the lookup-table translation block.
// Assumes one clock and both resets synchronous, active high.
`timescale 1ns/1ns
module blt_lut_xlat_checker
  import blt_pkg::*;
#(
  parameter int N_ENTRIES = LUT_ENTRIES
) (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_fund_rst,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire blt_req_t    i_req,
  input wire blt_rsp_t    o_rsp,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst || i_fund_rst);
  // No valid flag written since the last fundamental reset
  logic clean_ff;
  always_ff @(posedge i_clk) begin
    if (i_fund_rst) clean_ff <= 1'b1;
    else if (i_wr && (i_addr == ADDR_LUT_LOW_WORD)) clean_ff <= 1'b0;
  end
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0) else $error("read data without a read");
  a_rsp_timing: assert property (
    i_req.valid |=> o_rsp.valid) else $error("response missing");
  a_rsp_cause: assert property (
    o_rsp.valid |-> $past(i_req.valid)) else $error("response without request");
  a_ur_addr: assert property (
    o_rsp.valid && o_rsp.ur |-> o_rsp.addr == 64'h0) else $error("refused with address");
  a_req_id_kept: assert property (
    i_req.valid |=> o_rsp.req_id == $past(i_req.req_id)) else $error("requester id lost");
  a_cpl_id_kept: assert property (
    i_req.valid && i_req.is_cpl |=> o_rsp.cpl_id == $past(i_req.cpl_id))
    else $error("completer id lost");
  a_req_no_cpl: assert property (
    i_req.valid && !i_req.is_cpl |=> o_rsp.cpl_id == 16'h0) else $error("stray completer id");
  a_fund_invalid: assert property (
    clean_ff && i_req.valid |=> o_rsp.ur) else $error("entry valid after fundamental reset");
  c_ok: cover property (o_rsp.valid && !o_rsp.ur);
  c_ur: cover property (o_rsp.valid && o_rsp.ur);
  c_irq: cover property ($rose(o_irq));
endmodule // blt_lut_xlat_checker
bind blt_lut_xlat blt_lut_xlat_checker #(.N_ENTRIES(N_ENTRIES)) chk_u (.i_clk(i_clk),
  .i_srst(i_srst), .i_fund_rst(i_fund_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_req(i_req), .o_rsp(o_rsp), .o_irq(o_irq));

// ===== verif/tb.sv
// Self-checking bench for the lookup-table translation block.
// Assumes blt_pkg, the requester model and the checker are compiled first.
`timescale 1ns/1ns
module tb;
  import blt_pkg::*;
  localparam logic [63:0] OK_IN  = 64'h0000_0000_4000_07a5;
  localparam logic [63:0] OK_OUT = 64'h0000_0012_abcd_e1a5;
  logic        i_clk = 0, i_srst = 1, i_fund_rst = 1, i_wr = 0, i_rd = 0, go = 0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic        o_irq;
  blt_req_t    cmd = '0, i_req;
  blt_rsp_t    o_rsp;
  int          errors = 0, samples_checked = 0;
  blt_lut_xlat dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_fund_rst(i_fund_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_req(i_req),
    .o_rsp(o_rsp), .o_irq(o_irq));
  blt_requester req_u (.i_clk(i_clk), .i_go(go), .i_cmd(cmd), .o_req(i_req));
  initial forever #4 i_clk = ~i_clk;
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", o_rdata, e);
  endtask
  task automatic ent(logic [31:0] p, logic [31:0] lo, logic [31:0] hi);
    wr(ADDR_LUT_ENTRY_POINTER, p);
    wr(ADDR_LUT_LOW_WORD, lo);
    wr(ADDR_LUT_HIGH_WORD, hi);
  endtask
  task automatic req(logic w, logic c, logic a64, logic [63:0] a, logic ur, logic [63:0] xa,
                     logic [2:0] xp);
    @(posedge i_clk);
    cmd <= {1'b1, w, c, a64, a, 16'h1234, 16'h5678};
    go  <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    #1 chk("ur", o_rsp.ur, ur);
    chk("addr", o_rsp.addr, xa);
    chk("ids", {o_rsp.valid, o_rsp.req_id, o_rsp.cpl_id}, {17'h11234, c ? 16'h5678 : 16'h0});
    if (!ur) chk("part", o_rsp.part, xp);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_table();
    wr(ADDR_WINDOW_SETUP_REG, 32'h0000_250e);
    ent(32'h0000_0003, 32'habcd_e005, 32'h0000_0012);
    rd(ADDR_LUT_LOW_WORD, 32'habcd_e005);
    rd(ADDR_LUT_MID_WORD, 32'habcd_e000);
    rd(ADDR_LUT_HIGH_WORD, 32'h0000_0012);
    ent(32'h0000_0105, 32'h0000_1003, 32'h0000_0000);
    rd(ADDR_LUT_LOW_WORD, 32'h0000_1003);
    wr(ADDR_LUT_ENTRY_POINTER, 32'h0000_0018);
    rd(ADDR_LUT_LOW_WORD, 32'h0000_0000);
    rd(8'h3c, 32'h0000_0000);
  endtask
  task automatic t_xlat();
    req(1'b0, 1'b1, 1'b1, OK_IN, 1'b0, OK_OUT, 3'h2);
    req(1'b0, 1'b0, 1'b1, 64'h3200, 1'b1, 64'h0, 3'h0);
    req(1'b0, 1'b0, 1'b1, 64'h0800, 1'b1, 64'h0, 3'h0);
    req(1'b1, 1'b0, 1'b1, 64'h5_8765_4321, 1'b0, 64'h8765_5321, 3'h1);
    req(1'b1, 1'b0, 1'b0, 64'h5_0000_0010, 1'b1, 64'h0, 3'h0);
    wr(ADDR_PART_CTRL, 32'h0000_00fb);
    req(1'b0, 1'b0, 1'b1, OK_IN, 1'b1, 64'h0, 3'h0);
    wr(ADDR_PART_CTRL, 32'h0000_02ff);
    req(1'b0, 1'b0, 1'b1, OK_IN, 1'b1, 64'h0, 3'h0);
    wr(ADDR_PART_CTRL, 32'h0000_00ff);
  endtask
  task automatic t_irq();
    wr(ADDR_IRQ_CLEAR, 32'h0000_000f);
    wr(ADDR_IRQ_ENABLE, 32'h0000_0008);
    req(1'b0, 1'b0, 1'b1, OK_IN, 1'b0, OK_OUT, 3'h2);
    rd(ADDR_IRQ_STATUS, 32'h0000_0008);
    chk("irq", o_irq, 1'b1);
    wr(ADDR_IRQ_CLEAR, 32'h0000_0008);
    rd(ADDR_IRQ_STATUS, 32'h0000_0000);
    chk("irq", o_irq, 1'b0);
  endtask
  task automatic t_reset();
    @(posedge i_clk);
    i_srst <= 1'b1;
    @(posedge i_clk);
    i_srst <= 1'b0;
    req(1'b0, 1'b0, 1'b1, OK_IN, 1'b0, OK_OUT, 3'h2);
    @(posedge i_clk);
    i_fund_rst <= 1'b1;
    @(posedge i_clk);
    i_fund_rst <= 1'b0;
    req(1'b0, 1'b0, 1'b1, OK_IN, 1'b1, 64'h0, 3'h0);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_srst     <= 1'b0;
    i_fund_rst <= 1'b0;
    t_table();
    t_xlat();
    t_irq();
    t_reset();
    conclude();
  end
endmodule // tb
